// *** sfapd_regs.svh ***
// bit positions, reset values, opcodes and size constants of the protect block
`ifndef SFAPD_REGS_SVH
`define SFAPD_REGS_SVH
`define SFAPD_POS_SPAN0 2
`define SFAPD_POS_SPAN2 4
`define SFAPD_POS_LOW_END 5
`define SFAPD_POS_SMALL 6
`define SFAPD_POS_QUAD 9
`define SFAPD_POS_INVERT 14
`define SFAPD_POS_SUSPEND 15
`define SFAPD_RST_QUAD 1'b1
`define SFAPD_RST_INVERT 1'b0
`define SFAPD_RST_SPAN 3'h0
`define SFAPD_RST_LOW_END 1'b0
`define SFAPD_RST_SMALL 1'b0
`define SFAPD_RST_SUSPEND 1'b0
`define SFAPD_OP_SUSPEND 8'h75
`define SFAPD_OP_RESUME 8'h7a
`define SFAPD_OP_PAGE_PROG 8'h02
`define SFAPD_OP_ERASE_4K 8'h20
`define SFAPD_OP_ERASE_32K 8'h52
`define SFAPD_OP_ERASE_64K 8'hd8
`define SFAPD_OP_CHIP_ERASE_A 8'h60
`define SFAPD_OP_CHIP_ERASE_B 8'hc7
`define SFAPD_ARRAY_LAST 24'h7fffff
`define SFAPD_LOG2_PAGE 5'h08
`define SFAPD_LOG2_4K 5'h0c
`define SFAPD_LOG2_32K 5'h0f
`define SFAPD_LOG2_64K 5'h10
`define SFAPD_LOG2_ARRAY 5'h17
`define SFAPD_LOG2_BLOCK_BASE 5'h10
`define SFAPD_LOG2_SECTOR_BASE 5'h0b
`define SFAPD_LOG2_SECTOR_MAX 5'h0f
`define SFAPD_SPAN_NONE 3'h0
`define SFAPD_SPAN_ALL 3'h7
`define SFAPD_SPAN_SECTOR_CAP 3'h4
`define SFAPD_PIN_IDLE 2'h3
`endif

// *** sfapd_pkg.sv ***
// types and shared helpers of the flash array protect decoder
`include "sfapd_regs.svh"
package sfapd_pkg;
  typedef struct packed {
    logic small_granule_select;
    logic region_from_low_end;
    logic [2:0] protect_span;
    logic protect_invert;
  } sfapd_prot_type;

  typedef struct packed {
    logic present;
    logic [23:0] lo;
    logic [23:0] hi;
  } sfapd_range_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
  } sfapd_cmd_type;

  typedef enum logic [1:0] {
    sfapd_cls_other,
    sfapd_cls_modify,
    sfapd_cls_suspend,
    sfapd_cls_resume
  } sfapd_class_type;

  function automatic logic [23:0] sfapd_mask(input logic [4:0] lg);
    sfapd_mask = (24'h1 << lg) - 24'h1;
  endfunction : sfapd_mask
endpackage : sfapd_pkg

// *** sfapd_range.sv ***
// combinational decode of the normal protected range from the span bits
module sfapd_range
  import sfapd_pkg::*;
(
  input wire sfapd_prot_type prot,
  output sfapd_range_type region
);
  logic [4:0] lg;
  logic [23:0] mask;

  always_comb begin
    if (prot.small_granule_select) begin
      // 10x and 110 both cap at the largest sector group
      if (prot.protect_span >= `SFAPD_SPAN_SECTOR_CAP) begin
        lg = `SFAPD_LOG2_SECTOR_MAX;
      end else begin
        lg = `SFAPD_LOG2_SECTOR_BASE + {2'h0, prot.protect_span};
      end
    end else begin
      lg = `SFAPD_LOG2_BLOCK_BASE + {2'h0, prot.protect_span};
    end
    mask = sfapd_mask(lg);
    region.present = (prot.protect_span != `SFAPD_SPAN_NONE); // [RULE_09]
    if (prot.protect_span == `SFAPD_SPAN_ALL) begin
      region.lo = 24'h000000; // [RULE_09]
      region.hi = `SFAPD_ARRAY_LAST;
    end else if (prot.region_from_low_end) begin
      region.lo = 24'h000000; // [RULE_07] [RULE_08]
      region.hi = mask;
    end else begin
      region.lo = `SFAPD_ARRAY_LAST & ~mask; // [RULE_07] [RULE_08]
      region.hi = `SFAPD_ARRAY_LAST;
    end
  end
endmodule : sfapd_range

// *** sfapd_top.sv ***
// status bits, protect decode and command gating of the flash array
//
// Contract
// [RULE_01] quad enable bit, factory one, frees data pins
// [RULE_02] host avoids quad enable with tied pins
// [RULE_03] protect invert bit, default zero
// [RULE_04] invert swaps protected and unprotected ranges
// [RULE_05] suspend opcode sets suspend flag
// [RULE_06] resume opcode or power cycle clears flag
// [RULE_07] block granularity ranges double from top/bottom
// [RULE_08] sector granularity ranges 4KB to 32KB
// [RULE_09] span zero none, span seven all
// [RULE_10] inverted: zero all, seven none, complement
// [RULE_11] ignore program/erase touching protected location
// [RULE_12] span bits held at three status positions
// [RULE_13] top/bottom selector, zero means top
// [RULE_14] sector select, one means 4KB granules
// [RULE_15] check whole erase unit, chip erase too
// [RULE_16] protected region recomputed from current bits
module sfapd_top
  import sfapd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic status_wr_valid,
  input wire logic [15:0] status_wr_data,
  input wire logic cmd_valid,
  input wire sfapd_cmd_type cmd,
  input wire logic [1:0] core_line_out,
  input wire logic [1:0] core_line_oe,
  input wire logic data_line_two_in,
  input wire logic data_line_three_in,
  output logic [15:0] status_value,
  output logic quad_lines_enable,
  output logic array_op_go,
  output logic array_op_blocked,
  output sfapd_range_type array_op_span,
  output logic data_line_two_out,
  output logic data_line_two_oe,
  output logic data_line_three_out,
  output logic data_line_three_oe,
  output logic [1:0] quad_lines_rx,
  output logic [1:0] legacy_pin_level
);
  // reset stands for the power cycle; nonvolatile bits return to factory
  // values, as there is no backing store in this block
  logic protect_invert;
  logic suspend_flag;
  logic small_granule_select;
  logic region_from_low_end;
  logic protect_span_bit2;
  logic protect_span_bit1;
  logic protect_span_bit0;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  sfapd_prot_type prot;
  sfapd_range_type region;
  sfapd_range_type target;
  sfapd_class_type cls;
  logic next_blocked;
  logic judged;

  // reads, status and id opcodes fall to other and are never judged
  function automatic sfapd_class_type classify(input logic [7:0] op);
    case (op)
      `SFAPD_OP_PAGE_PROG,
      `SFAPD_OP_ERASE_4K,
      `SFAPD_OP_ERASE_32K,
      `SFAPD_OP_ERASE_64K,
      `SFAPD_OP_CHIP_ERASE_A,
      `SFAPD_OP_CHIP_ERASE_B: classify = sfapd_cls_modify;
      `SFAPD_OP_SUSPEND: classify = sfapd_cls_suspend;
      `SFAPD_OP_RESUME: classify = sfapd_cls_resume;
      default: classify = sfapd_cls_other;
    endcase
  endfunction : classify

  function automatic logic [4:0] unit_log2(input logic [7:0] op);
    case (op)
      `SFAPD_OP_PAGE_PROG: unit_log2 = `SFAPD_LOG2_PAGE;
      `SFAPD_OP_ERASE_4K: unit_log2 = `SFAPD_LOG2_4K;
      `SFAPD_OP_ERASE_32K: unit_log2 = `SFAPD_LOG2_32K;
      `SFAPD_OP_ERASE_64K: unit_log2 = `SFAPD_LOG2_64K;
      default: unit_log2 = `SFAPD_LOG2_ARRAY;
    endcase
  endfunction : unit_log2

  // any shared address between the two spans
  function automatic logic spans_meet(input sfapd_range_type a,
                                      input sfapd_range_type b);
    spans_meet = a.present && b.present && a.lo <= b.hi && b.lo <= a.hi;
  endfunction : spans_meet

  // span b lies wholly inside span a
  function automatic logic span_holds(input sfapd_range_type a,
                                      input sfapd_range_type b);
    span_holds = a.present && b.present && b.lo >= a.lo && b.hi <= a.hi;
  endfunction : span_holds

  // live view of the protect bits, no pipeline stage in between
  assign prot.small_granule_select = small_granule_select;
  assign prot.region_from_low_end = region_from_low_end;
  assign prot.protect_span = {protect_span_bit2, protect_span_bit1,
                              protect_span_bit0};
  assign prot.protect_invert = protect_invert;

  sfapd_range u_range (
    .prot(prot), // [RULE_16]
    .region(region)
  );

  assign cls = classify(cmd.opcode);
  assign judged = cmd_valid && cls == sfapd_cls_modify;

  // a page program is judged over its whole page, the safe reading
  // address bit 23 lies past the 8MB array and is dropped
  always_comb begin
    logic [23:0] mask;
    mask = sfapd_mask(unit_log2(cmd.opcode));
    target.present = 1'b1;
    target.lo = {1'b0, cmd.addr[22:0]} & ~mask; // [RULE_15]
    target.hi = ({1'b0, cmd.addr[22:0]} & ~mask) | mask; // [RULE_15]
  end

  always_comb begin
    if (protect_invert) begin
      // protected set is outside the range; empty range protects all
      next_blocked = !span_holds(region, target); // [RULE_04] [RULE_10]
    end else begin
      next_blocked = spans_meet(region, target); // [RULE_11]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quad_lines_enable <= `SFAPD_RST_QUAD; // [RULE_01]
      protect_invert <= `SFAPD_RST_INVERT; // [RULE_03]
      small_granule_select <= `SFAPD_RST_SMALL; // [RULE_14]
      region_from_low_end <= `SFAPD_RST_LOW_END; // [RULE_13]
      {protect_span_bit2, protect_span_bit1, protect_span_bit0} <=
        `SFAPD_RST_SPAN; // [RULE_12]
    end else if (status_wr_valid) begin
      quad_lines_enable <= status_wr_data[`SFAPD_POS_QUAD]; // [RULE_01]
      protect_invert <= status_wr_data[`SFAPD_POS_INVERT]; // [RULE_03]
      small_granule_select <= status_wr_data[`SFAPD_POS_SMALL]; // [RULE_14]
      region_from_low_end <= status_wr_data[`SFAPD_POS_LOW_END]; // [RULE_13]
      {protect_span_bit2, protect_span_bit1, protect_span_bit0} <=
        status_wr_data[`SFAPD_POS_SPAN2:`SFAPD_POS_SPAN0]; // [RULE_12]
    end
  end

  // suspend flag is read only: status writes never touch it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      suspend_flag <= `SFAPD_RST_SUSPEND; // [RULE_06]
    end else if (cmd_valid && cls == sfapd_cls_suspend) begin
      suspend_flag <= 1'b1; // [RULE_05]
    end else if (cmd_valid && cls == sfapd_cls_resume) begin
      suspend_flag <= 1'b0; // [RULE_06]
    end
  end

  // verdict pulses one cycle; the span holds for the host to inspect
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      array_op_go <= 1'b0;
      array_op_blocked <= 1'b0;
      array_op_span <= '0;
    end else begin
      array_op_go <= judged && !next_blocked; // [RULE_11]
      array_op_blocked <= judged && next_blocked; // [RULE_11]
      if (judged) begin
        array_op_span <= target;
      end
    end
  end

  // status word is registered, so it reads one edge behind a write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_value <= 16'h0000;
    end else begin
      status_value <= 16'h0000;
      status_value[`SFAPD_POS_SPAN2:`SFAPD_POS_SPAN0] <= prot.protect_span;
      status_value[`SFAPD_POS_LOW_END] <= region_from_low_end;
      status_value[`SFAPD_POS_SMALL] <= small_granule_select;
      status_value[`SFAPD_POS_QUAD] <= quad_lines_enable;
      status_value[`SFAPD_POS_INVERT] <= protect_invert;
      status_value[`SFAPD_POS_SUSPEND] <= suspend_flag;
    end
  end

  // pin inputs come from outside; two flops before anything reads them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta <= `SFAPD_PIN_IDLE;
      pin_sync <= `SFAPD_PIN_IDLE;
    end else begin
      pin_meta <= {data_line_three_in, data_line_two_in};
      pin_sync <= pin_meta;
    end
  end

  // drive only in quad mode, so a pin tied to a rail is never fought
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_line_two_out <= 1'b0;
      data_line_two_oe <= 1'b0;
      data_line_three_out <= 1'b0;
      data_line_three_oe <= 1'b0;
    end else begin
      data_line_two_out <= core_line_out[0];
      data_line_two_oe <= quad_lines_enable && core_line_oe[0]; // [RULE_01]
      data_line_three_out <= core_line_out[1];
      data_line_three_oe <= quad_lines_enable && core_line_oe[1]; // [RULE_01]
    end
  end

  // receive side: quad data or legacy pin levels, never both at once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quad_lines_rx <= 2'h0;
      legacy_pin_level <= `SFAPD_PIN_IDLE;
    end else begin
      quad_lines_rx <= quad_lines_enable ? pin_sync : 2'h0; // [RULE_01]
      legacy_pin_level <= quad_lines_enable ? `SFAPD_PIN_IDLE : pin_sync;
    end
  end
endmodule : sfapd_top

// *** sfapd_checker.sv ***
// assertion checker of the flash array protect decoder
module sfapd_checker
  import sfapd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic status_wr_valid,
  input wire logic [15:0] status_wr_data,
  input wire logic cmd_valid,
  input wire sfapd_cmd_type cmd,
  input wire logic [1:0] core_line_oe,
  input wire logic [15:0] status_value,
  input wire logic quad_lines_enable,
  input wire logic array_op_go,
  input wire logic array_op_blocked,
  input wire sfapd_range_type array_op_span,
  input wire logic data_line_two_oe,
  input wire logic [1:0] legacy_pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic judged;
  logic quiet;
  logic last_wr;
  // status_value lags the live bits one edge after a write
  always_ff @(posedge sys_clk) begin
    last_wr <= status_wr_valid;
  end
  assign judged = cmd_valid && (cmd.opcode inside
    {8'h02, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7});
  assign quiet = judged && !last_wr;
  sequence s_wr;
    status_wr_valid ##1 1'b1;
  endsequence
  sequence s_sus;
    cmd_valid && cmd.opcode == 8'h75 ##1 1'b1;
  endsequence
  sequence s_res;
    cmd_valid && cmd.opcode == 8'h7a ##1 1'b1;
  endsequence
  chk_factory_bits: assert property (
    $fell(rst) |-> quad_lines_enable ##1 status_value == 16'h0200)
    else $error("factory status wrong");
  chk_invert_land: assert property (
    s_wr |=> status_value[14] == $past(status_wr_data[14], 2))
    else $error("invert bit not stored");
  chk_span_land: assert property (
    s_wr |=> status_value[6:2] == $past(status_wr_data[6:2], 2))
    else $error("span bits not stored");
  chk_quad_land: assert property (
    status_wr_valid |=> quad_lines_enable == $past(status_wr_data[9]))
    else $error("quad bit not stored");
  chk_one_verdict: assert property (
    judged |=> array_op_go != array_op_blocked)
    else $error("verdict count wrong");
  chk_chip_span: assert property (
    cmd_valid && (cmd.opcode inside {8'h60, 8'hc7}) |=>
    array_op_span == {1'b1, 24'h000000, 24'h7fffff})
    else $error("chip erase span wrong");
  chk_suspend_set: assert property (
    s_sus |=> status_value[15])
    else $error("suspend flag not set");
  chk_resume_clear: assert property (
    s_res |=> !status_value[15])
    else $error("suspend flag not cleared");
  chk_span_all: assert property (
    quiet && status_value[4:2] == 3'h7 && !status_value[14] |=>
    array_op_blocked)
    else $error("full span not blocked");
  chk_invert_none: assert property (
    quiet && status_value[4:2] == 3'h7 && status_value[14] |=>
    array_op_go)
    else $error("inverted full span blocked");
  chk_legacy_idle: assert property (
    quad_lines_enable [*2] |-> legacy_pin_level == 2'h3)
    else $error("legacy level not idle");
  chk_oe_follow: assert property (
    !$past(rst) |->
    data_line_two_oe == $past(quad_lines_enable && core_line_oe[0]))
    else $error("pin enable wrong");
endmodule : sfapd_checker
bind sfapd_top sfapd_checker sfapd_checker_i (.sys_clk, .rst,
  .status_wr_valid, .status_wr_data, .cmd_valid, .cmd, .core_line_oe,
  .status_value, .quad_lines_enable, .array_op_go, .array_op_blocked,
  .array_op_span, .data_line_two_oe, .legacy_pin_level);

// *** sfapd_host.sv ***
// host controller model driving status writes and commands
module sfapd_host
  import sfapd_pkg::*;
(
  input wire logic sys_clk,
  output logic status_wr_valid,
  output logic [15:0] status_wr_data,
  output logic cmd_valid,
  output sfapd_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    status_wr_valid = 1'b0;
    status_wr_data = 16'h0000;
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // quad on is only written while the pins float, never tied
  task wr_status(input logic [15:0] d);
    @(negedge sys_clk);
    status_wr_valid = 1'b1;
    status_wr_data = d;
    @(negedge sys_clk);
    status_wr_valid = 1'b0;
    status_wr_data = ~d;
  endtask : wr_status
  // released fields flip so stale values are never taken for live ones
  task send(input logic [7:0] op, input logic [23:0] a);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = {op, a};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask : send
endmodule : sfapd_host

// *** sfapd_top_test.sv ***
// testbench of the flash array protect decoder
module sfapd_top_test import sfapd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic status_wr_valid, cmd_valid;
  logic [15:0] status_wr_data, status_value, s;
  sfapd_cmd_type cmd;
  logic [1:0] core_line_out = 2'h1;
  logic [1:0] core_line_oe = 2'h3;
  logic two_in, three_in, quad_lines_enable, array_op_go, array_op_blocked;
  sfapd_range_type array_op_span;
  logic two_out, two_oe, three_out, three_oe;
  logic [1:0] quad_lines_rx, legacy_pin_level, res;
  logic [7:0] pins;
  logic [7:0] op;
  logic [23:0] a, lo, hi;
  int errors = 0;
  int compares = 0;
  // {status, opcode, address, {go, blocked}, low, high}
  localparam logic [97:0] tab [15] = '{
    {16'h0004, 8'hd8, 24'h7e0000, 2'h1, 24'h7e0000, 24'h7effff},
    {16'h0004, 8'hd8, 24'h7d0000, 2'h2, 24'h7d0000, 24'h7dffff},
    {16'h0038, 8'h20, 24'h3ff000, 2'h1, 24'h3ff000, 24'h3fffff},
    {16'h0038, 8'h20, 24'h400000, 2'h2, 24'h400000, 24'h400fff},
    {16'h0044, 8'h20, 24'h7ff123, 2'h1, 24'h7ff000, 24'h7fffff},
    {16'h0044, 8'h20, 24'h7fe000, 2'h2, 24'h7fe000, 24'h7fefff},
    {16'h0074, 8'h02, 24'h007f00, 2'h1, 24'h007f00, 24'h007fff},
    {16'h0074, 8'h02, 24'h008000, 2'h2, 24'h008000, 24'h0080ff},
    {16'h0000, 8'h60, 24'h000000, 2'h2, 24'h000000, 24'h7fffff},
    {16'h007c, 8'hc7, 24'h000000, 2'h1, 24'h000000, 24'h7fffff},
    {16'h4000, 8'h02, 24'h123400, 2'h1, 24'h123400, 24'h1234ff},
    {16'h401c, 8'h52, 24'h000000, 2'h2, 24'h000000, 24'h007fff},
    {16'h4044, 8'h20, 24'h7ff000, 2'h2, 24'h7ff000, 24'h7fffff},
    {16'h4044, 8'h20, 24'h7fe000, 2'h1, 24'h7fe000, 24'h7fefff},
    {16'h0000, 8'h03, 24'h000000, 2'h0, 24'h000000, 24'h000000}};
  // pull-ups hold an undriven data line high
  assign two_in = two_oe ? two_out : 1'b1;
  assign three_in = three_oe ? three_out : 1'b1;
  assign pins = {two_out, three_out, two_oe, three_oe, legacy_pin_level,
                 quad_lines_rx};
  sfapd_host sfapd_host_i (.sys_clk(sys_clk),
    .status_wr_valid(status_wr_valid), .status_wr_data(status_wr_data),
    .cmd_valid(cmd_valid), .cmd(cmd));
  sfapd_top sfapd_top_i (.sys_clk(sys_clk), .rst(rst),
    .status_wr_valid(status_wr_valid), .status_wr_data(status_wr_data),
    .cmd_valid(cmd_valid), .cmd(cmd), .core_line_out(core_line_out),
    .core_line_oe(core_line_oe), .data_line_two_in(two_in),
    .data_line_three_in(three_in), .status_value(status_value),
    .quad_lines_enable(quad_lines_enable), .array_op_go(array_op_go),
    .array_op_blocked(array_op_blocked), .array_op_span(array_op_span),
    .data_line_two_out(two_out), .data_line_two_oe(two_oe),
    .data_line_three_out(three_out), .data_line_three_oe(three_oe),
    .quad_lines_rx(quad_lines_rx), .legacy_pin_level(legacy_pin_level));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task check(input logic [48:0] seen, input logic [48:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task do_reset;
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : do_reset
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
  initial begin
    do_reset();
    check(status_value, 16'h0200);
    check({quad_lines_enable, array_op_go, array_op_blocked}, 3'h4);
    $display("test reset done");
    for (int i = 0; i < 15; i++) begin
      {s, op, a, res, lo, hi} = tab[i];
      sfapd_host_i.wr_status(s);
      sfapd_host_i.send(op, a);
      check({array_op_go, array_op_blocked}, res);
      if (res != 2'h0) check(array_op_span, {1'b1, lo, hi});
      check(status_value, s & 16'h427c);
    end
    $display("test protect done");
    repeat (5) @(negedge sys_clk);
    check(pins, 8'h8c);
    sfapd_host_i.wr_status(16'h0200);
    repeat (5) @(negedge sys_clk);
    check(pins, 8'hbd);
    core_line_oe = 2'h1;
    repeat (5) @(negedge sys_clk);
    check(pins, 8'haf);
    $display("test pins done");
    sfapd_host_i.send(8'h75, 24'h000000);
    @(negedge sys_clk);
    check(status_value[15], 1'b1);
    sfapd_host_i.send(8'h7a, 24'h000000);
    @(negedge sys_clk);
    check(status_value[15], 1'b0);
    sfapd_host_i.send(8'h75, 24'h000000);
    do_reset();
    check(status_value, 16'h0200);
    $display("test suspend done");
    wrap_up();
  end
endmodule : sfapd_top_test
